// ---- core/pmc_top.sv ----
// Functional notes
// - Offers idle, sleep, power-down and deep power-down modes.
// - Idle halts instruction execution until reset or interrupt.
// - Peripheral clocks keep running during idle.
// - Sleep stops the system oscillator and gates every internal clock.
// - Sleep keeps state, SRAM, pin levels and all registers but PLL and dividers unchanged.
// - Sleep disables the RC oscillator output but keeps it powered.
// - The 32 kHz RTC oscillator keeps running in sleep.
// - Sleep entry switches the PLL off and disconnects it.
// - Sleep entry clears CPU and USB clock dividers to zero.
// - Sleep ends on reset or a clockless wake interrupt.
// - RC source: resume after 4 oscillator cycles.
// - Main oscillator source: resume after 4096 oscillator cycles.
// - Power-down does all sleep actions and powers off the RC oscillator.
// - Power-down wake on RC: 60 us start-up, then 4 cycles.
// - Each peripheral clock can be gated off individually.
// - Each peripheral has its own programmable clock divider.
// - CPU clock set by source, PLL settings or CPU divider.
// - Separate domain keeps RTC and battery RAM alive.
`include "pmc_defs.svh"

module pmc_top
   import pmc_pkg::*;
#(
   parameter int NPER = 16,
   parameter int MAIN_WAKE_CYC = `PMC_MAIN_WAKE_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Wake sources
   input wire logic irq_req,
   input wire logic wake_pin,
   // Clock and power controls
   output pmc_clk_ctrl_t clk_ctrl,
   output logic [1:0] clk_src_sel,
   output logic [7:0] pll_mul,
   output logic [7:0] cpu_div,
   output logic [7:0] usb_div,
   output logic [NPER-1:0] per_clk_en
);

   localparam int START_CYC = (`PMC_IRC_START_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS;
   localparam int CW = 13;

   // Refuse sizes the register map cannot hold
   if (NPER < 1 || NPER > 16 || MAIN_WAKE_CYC < 1 || MAIN_WAKE_CYC > 8191) begin : g_chk
      $error("NPER must be 1 to 16 and MAIN_WAKE_CYC 1 to 8191");
   end

   // Wake pin synchroniser; first stage read only by the second
   logic wk_s1_r, wk_s2_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wk_s1_r <= 1'b0;
         wk_s2_r <= 1'b0;
      end else begin
         wk_s1_r <= wake_pin;
         wk_s2_r <= wk_s1_r;
      end
   end

   // Software registers
   pmc_mode_t mode_r, mode_nxt;
   logic [1:0] src_r, src_nxt;
   logic [15:0] pll_r, pll_nxt;
   logic [7:0] cdiv_r, cdiv_nxt;
   logic [7:0] udiv_r, udiv_nxt;
   logic [15:0] gate_r, gate_nxt;
   logic [31:0] pdiv_r, pdiv_nxt;
   logic wcause_r, wcause_nxt;
   // APB answer
   logic [31:0] rdata_r, rdata_nxt;
   logic rdy_r, rdy_nxt;
   logic err_r, err_nxt;
   // Sequencer
   pmc_state_t st_r, st_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;

   logic setup, wr_acc, hit, enter_slp, woke;

   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & rdy_r & pwrite & ~err_r;

   // Sleep entry clears dividers and PLL for every sleep-like mode
   assign enter_slp = (st_r == PMC_S_RUN) &&
                      (mode_r == PMC_M_SLEEP || mode_r == PMC_M_PDOWN ||
                       mode_r == PMC_M_DEEP);
   assign woke = (st_nxt == PMC_S_RUN) && (st_r != PMC_S_RUN);

   // Address decode and read mux, prepared in the setup cycle
   always_comb begin
      hit = 1'b1;
      rdata_nxt = 32'h00000000;
      if (paddr == `PMC_MODE_OFS) begin
         rdata_nxt[2:0] = mode_r;
      end else if (paddr == `PMC_CLKSRC_OFS) begin
         rdata_nxt[1:0] = src_r;
      end else if (paddr == `PMC_PLL_OFS) begin
         rdata_nxt[15:0] = pll_r;
      end else if (paddr == `PMC_CPUDIV_OFS) begin
         rdata_nxt[7:0] = cdiv_r;
      end else if (paddr == `PMC_USBDIV_OFS) begin
         rdata_nxt[7:0] = udiv_r;
      end else if (paddr == `PMC_PGATE_OFS) begin
         rdata_nxt[15:0] = gate_r;
      end else if (paddr == `PMC_PDIV_OFS) begin
         rdata_nxt = pdiv_r;
      end else if (paddr == `PMC_STAT_OFS) begin
         rdata_nxt[2:0] = st_r;
         rdata_nxt[`PMC_STAT_MODE_LSB +: 3] = mode_r;
         rdata_nxt[`PMC_STAT_WAKE_BIT] = wcause_r;
         rdata_nxt[`PMC_STAT_BUSY_BIT] = (st_r != PMC_S_RUN);
      end else begin
         hit = 1'b0;
      end
      if (!setup || pwrite) begin
         rdata_nxt = prdata;
      end
      // One wait-free access phase: ready rises the cycle after setup
      rdy_nxt = setup;
      err_nxt = setup & ~hit;
   end

   // Register next values
   always_comb begin
      mode_nxt = mode_r;
      src_nxt = src_r;
      pll_nxt = pll_r;
      cdiv_nxt = cdiv_r;
      udiv_nxt = udiv_r;
      gate_nxt = gate_r;
      pdiv_nxt = pdiv_r;
      wcause_nxt = wcause_r;
      if (wr_acc) begin
         if (paddr == `PMC_MODE_OFS) begin
            if (pwdata[2:0] <= 3'h4) begin
               mode_nxt = pmc_mode_t'(pwdata[2:0]);
            end
         end else if (paddr == `PMC_CLKSRC_OFS) begin
            if (pwdata[1:0] != 2'h3) begin
               src_nxt = pwdata[1:0];
            end
         end else if (paddr == `PMC_PLL_OFS) begin
            pll_nxt = pwdata[15:0];
         end else if (paddr == `PMC_CPUDIV_OFS) begin
            cdiv_nxt = pwdata[7:0];
         end else if (paddr == `PMC_USBDIV_OFS) begin
            udiv_nxt = pwdata[7:0];
         end else if (paddr == `PMC_PGATE_OFS) begin
            gate_nxt = pwdata[15:0];
         end else if (paddr == `PMC_PDIV_OFS) begin
            pdiv_nxt = pwdata;
         end else if (paddr == `PMC_STAT_OFS) begin
            if (pwdata[`PMC_STAT_WAKE_BIT]) begin
               wcause_nxt = 1'b0;
            end
         end
      end
      // Hardware clears on entry; applied after the write logic, so the clear wins over any same-cycle write
      if (enter_slp) begin
         pll_nxt[`PMC_PLL_EN_BIT] = 1'b0;
         pll_nxt[`PMC_PLL_CON_BIT] = 1'b0;
         cdiv_nxt = `PMC_DIV_RST;
         udiv_nxt = `PMC_DIV_RST;
      end
      // Request is consumed on return to run; wake flag set beats clear
      if (woke) begin
         mode_nxt = PMC_M_RUN;
         wcause_nxt = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= PMC_M_RUN;
         src_r <= `PMC_CLKSRC_RST;
         pll_r <= `PMC_PLL_RST;
         cdiv_r <= `PMC_DIV_RST;
         udiv_r <= `PMC_DIV_RST;
         gate_r <= `PMC_PGATE_RST;
         pdiv_r <= `PMC_PDIV_RST;
         wcause_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rdy_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         src_r <= src_nxt;
         pll_r <= pll_nxt;
         cdiv_r <= cdiv_nxt;
         udiv_r <= udiv_nxt;
         gate_r <= gate_nxt;
         pdiv_r <= pdiv_nxt;
         wcause_r <= wcause_nxt;
         rdata_r <= rdata_nxt;
         rdy_r <= rdy_nxt;
         err_r <= err_nxt;
      end
   end

   // Power sequencer: mode entry, wake detection and wake delay
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      case (st_r)
         PMC_S_RUN: begin
            if (mode_r == PMC_M_IDLE) begin
               st_nxt = PMC_S_IDLE;
            end else if (mode_r == PMC_M_SLEEP) begin
               st_nxt = PMC_S_SLEEP;
            end else if (mode_r == PMC_M_PDOWN) begin
               st_nxt = PMC_S_PDOWN;
            end else if (mode_r == PMC_M_DEEP) begin
               st_nxt = PMC_S_DEEP;
            end
         end
         PMC_S_IDLE: begin
            // Peripherals still clocked, so any interrupt resumes
            if (irq_req || wk_s2_r) begin
               st_nxt = PMC_S_RUN;
            end
         end
         PMC_S_SLEEP: begin
            if (wk_s2_r) begin
               st_nxt = PMC_S_WAKE;
               if (src_r == PMC_SRC_MAIN) begin
                  cnt_nxt = CW'(MAIN_WAKE_CYC);
               end else begin
                  cnt_nxt = CW'(`PMC_IRC_WAKE_CYC);
               end
            end
         end
         PMC_S_PDOWN: begin
            if (wk_s2_r) begin
               if (src_r == PMC_SRC_MAIN) begin
                  st_nxt = PMC_S_WAKE;
                  cnt_nxt = CW'(MAIN_WAKE_CYC);
               end else begin
                  st_nxt = PMC_S_START;
                  cnt_nxt = CW'(START_CYC);
               end
            end
         end
         PMC_S_START: begin
            // RC oscillator powered and settling, output still off
            if (cnt_r <= CW'(1)) begin
               st_nxt = PMC_S_WAKE;
               cnt_nxt = CW'(`PMC_IRC_WAKE_CYC);
            end else begin
               cnt_nxt = cnt_r - CW'(1);
            end
         end
         PMC_S_WAKE: begin
            // Gates stay closed until the last counted cycle
            if (cnt_r <= CW'(1)) begin
               st_nxt = PMC_S_RUN;
            end else begin
               cnt_nxt = cnt_r - CW'(1);
            end
         end
         PMC_S_DEEP: begin
            // Only a reset leaves deep power-down
            st_nxt = PMC_S_DEEP;
         end
         default: begin
            st_nxt = PMC_S_RUN;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= PMC_S_RUN;
         cnt_r <= '0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Clock and power outputs, decoded from the next state to move with it
   pmc_clk_ctrl_t ctl_r, ctl_nxt;
   logic [NPER-1:0] pen_r, pen_nxt;
   logic per_run;

   always_comb begin
      ctl_nxt.cpu_en = 1'b0;
      ctl_nxt.osc_en = 1'b0;
      ctl_nxt.irc_out_en = 1'b0;
      ctl_nxt.irc_pwr_en = 1'b1;
      ctl_nxt.pll_en = 1'b0;
      ctl_nxt.pll_con = 1'b0;
      ctl_nxt.pin_hold = 1'b1;
      ctl_nxt.main_pwr_en = 1'b1;
      ctl_nxt.rtc_osc_en = 1'b1;
      per_run = 1'b0;
      case (st_nxt)
         PMC_S_RUN, PMC_S_IDLE: begin
            ctl_nxt.cpu_en = (st_nxt == PMC_S_RUN);
            ctl_nxt.osc_en = (src_r == PMC_SRC_MAIN);
            ctl_nxt.irc_out_en = (src_r == PMC_SRC_IRC);
            ctl_nxt.pll_en = pll_nxt[`PMC_PLL_EN_BIT];
            ctl_nxt.pll_con = pll_nxt[`PMC_PLL_CON_BIT] &
                              pll_nxt[`PMC_PLL_EN_BIT];
            ctl_nxt.pin_hold = 1'b0;
            per_run = 1'b1;
         end
         PMC_S_SLEEP: begin
            // Everything frozen; state held because no clock reaches it
            ctl_nxt.irc_pwr_en = 1'b1;
            ctl_nxt.pin_hold = 1'b1;
         end
         PMC_S_PDOWN: begin
            ctl_nxt.irc_pwr_en = 1'b0;
         end
         PMC_S_START: begin
            ctl_nxt.irc_pwr_en = 1'b1;
         end
         PMC_S_WAKE: begin
            // Oscillator restarted, core and peripherals still gated
            ctl_nxt.osc_en = (src_r == PMC_SRC_MAIN);
            ctl_nxt.irc_out_en = (src_r != PMC_SRC_MAIN);
         end
         PMC_S_DEEP: begin
            ctl_nxt.irc_pwr_en = 1'b0;
            ctl_nxt.main_pwr_en = 1'b0;
         end
         default: begin
            ctl_nxt.pin_hold = 1'b1;
         end
      endcase
   end

   // Per-peripheral gate and divider: code n divides by 2**n
   logic [2:0] pcnt_r [NPER];
   logic [2:0] pcnt_nxt [NPER];

   for (genvar i = 0; i < NPER; i++) begin : g_per
      logic [1:0] code;
      logic [2:0] top;
      assign code = pdiv_r[2*i +: 2];
      assign top = 3'((4'h1 << code) - 4'h1);
      always_comb begin
         pcnt_nxt[i] = pcnt_r[i];
         pen_nxt[i] = 1'b0;
         if (per_run && gate_r[i]) begin
            pen_nxt[i] = (pcnt_r[i] == 3'h0);
            pcnt_nxt[i] = (pcnt_r[i] >= top) ? 3'h0 : pcnt_r[i] + 3'h1;
         end
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pcnt_r[i] <= 3'h0;
         end else begin
            pcnt_r[i] <= pcnt_nxt[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_r <= '{cpu_en: 1'b1, osc_en: 1'b0, irc_out_en: 1'b1,
                    irc_pwr_en: 1'b1, pll_en: 1'b0, pll_con: 1'b0,
                    pin_hold: 1'b0, main_pwr_en: 1'b1,
                    rtc_osc_en: 1'b1};
         pen_r <= '0;
      end else begin
         ctl_r <= ctl_nxt;
         pen_r <= pen_nxt;
      end
   end

   // Outputs straight from flops
   assign prdata = rdata_r;
   assign pready = rdy_r;
   assign pslverr = err_r;
   assign clk_ctrl = ctl_r;
   assign clk_src_sel = src_r;
   assign pll_mul = pll_r[`PMC_PLL_MUL_LSB +: 8];
   assign cpu_div = cdiv_r;
   assign usb_div = udiv_r;
   assign per_clk_en = pen_r;

endmodule

// ---- core/pmc_defs.svh ----
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Register byte offsets
`define PMC_MODE_OFS 8'h00
`define PMC_CLKSRC_OFS 8'h04
`define PMC_PLL_OFS 8'h08
`define PMC_CPUDIV_OFS 8'h0C
`define PMC_USBDIV_OFS 8'h10
`define PMC_PGATE_OFS 8'h14
`define PMC_PDIV_OFS 8'h18
`define PMC_STAT_OFS 8'h1C

// Field positions
`define PMC_PLL_EN_BIT 0
`define PMC_PLL_CON_BIT 1
`define PMC_PLL_MUL_LSB 8
`define PMC_STAT_WAKE_BIT 8
`define PMC_STAT_BUSY_BIT 9
`define PMC_STAT_MODE_LSB 4

// Reset values
`define PMC_CLKSRC_RST 2'h0
`define PMC_PLL_RST 16'h0000
`define PMC_DIV_RST 8'h00
`define PMC_PGATE_RST 16'hFFFF
`define PMC_PDIV_RST 32'h00000000

// Timing
`define PMC_CLK_PERIOD_NS 50
`define PMC_IRC_START_NS 60000
`define PMC_IRC_WAKE_CYC 4
`define PMC_MAIN_WAKE_CYC 4096

`endif

// ---- core/pmc_pkg.sv ----
package pmc_pkg;

   // Software-requested power mode
   typedef enum logic [2:0] {
      PMC_M_RUN = 3'h0,
      PMC_M_IDLE = 3'h1,
      PMC_M_SLEEP = 3'h2,
      PMC_M_PDOWN = 3'h3,
      PMC_M_DEEP = 3'h4
   } pmc_mode_t;

   // Sequencer states, Gray along sleep-wake-run and pdown-start-wake-run
   typedef enum logic [2:0] {
      PMC_S_RUN = 3'b000,
      PMC_S_IDLE = 3'b001,
      PMC_S_SLEEP = 3'b011,
      PMC_S_WAKE = 3'b010,
      PMC_S_START = 3'b110,
      PMC_S_PDOWN = 3'b111,
      PMC_S_DEEP = 3'b101
   } pmc_state_t;

   // Previous system clock source
   typedef enum logic [1:0] {
      PMC_SRC_IRC = 2'h0,
      PMC_SRC_MAIN = 2'h1,
      PMC_SRC_RTC = 2'h2
   } pmc_src_t;

   // Clock and power controls toward core, oscillators and PLL
   typedef struct packed {
      logic cpu_en;
      logic osc_en;
      logic irc_out_en;
      logic irc_pwr_en;
      logic pll_en;
      logic pll_con;
      logic pin_hold;
      logic main_pwr_en;
      logic rtc_osc_en;
   } pmc_clk_ctrl_t;

endpackage

// ---- bench/pmc_properties.sv ----
module pmc_properties
   import pmc_pkg::*;
#(
   parameter int NPER = 16,
   parameter int MAIN_WAKE_CYC = 4096
) (
   // Clock, reset and APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Wake sources and clock controls
   input wire logic irq_req,
   input wire logic wake_pin,
   input wire pmc_clk_ctrl_t clk_ctrl,
   input wire logic [1:0] clk_src_sel,
   input wire logic [7:0] pll_mul,
   input wire logic [7:0] cpu_div,
   input wire logic [7:0] usb_div,
   input wire logic [NPER-1:0] per_clk_en
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Mode and gate mirrors, plus a wake counter
   logic wr;
   logic [2:0] mode_r, mode_nxt;
   logic [NPER-1:0] gate_r, gate_nxt;
   logic [1:0] settle_r, settle_nxt;
   logic [15:0] wk_r, wk_nxt;
   assign wr = psel && penable && pready && pwrite && !pslverr;

   // Counter only runs while the restarting oscillator is up
   always_comb begin
      mode_nxt = (wr && paddr == 8'h00 && clk_ctrl.cpu_en) ? pwdata[2:0] : mode_r;
      gate_nxt = (wr && paddr == 8'h14) ? pwdata[NPER-1:0] : gate_r;
      settle_nxt = (settle_r != 2'h0) ? settle_r - 2'h1 : 2'h0;
      if (wr && paddr == 8'h14)
         settle_nxt = 2'h3;
      wk_nxt = wk_r;
      if (mode_r == 3'h3 ? clk_ctrl.irc_pwr_en : clk_ctrl.irc_out_en | clk_ctrl.osc_en)
         wk_nxt = wk_r + 16'h1;
      if (clk_ctrl.cpu_en)
         wk_nxt = 16'h0;
   end

   // Helper registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= 3'h0;
         gate_r <= '1;
         settle_r <= 2'h0;
         wk_r <= 16'h0;
      end else begin
         mode_r <= mode_nxt;
         gate_r <= gate_nxt;
         settle_r <= settle_nxt;
         wk_r <= wk_nxt;
      end
   end

   // Accepted mode request while running
   sequence s_mode(logic [2:0] v);
      wr && paddr == 8'h00 && pwdata[2:0] == v && clk_ctrl.cpu_en;
   endsequence

   a_sleep_entry: assert property (
      s_mode(3'h2) |-> ##[1:3] (!clk_ctrl.cpu_en && !clk_ctrl.osc_en && !clk_ctrl.irc_out_en
         && clk_ctrl.irc_pwr_en && !clk_ctrl.pll_con && cpu_div == 8'h00 && usb_div == 8'h00))
      else $error("sleep entry incomplete");
   a_pdown_off: assert property (
      s_mode(3'h3) |-> ##[1:3] (!clk_ctrl.cpu_en && !clk_ctrl.irc_pwr_en && !clk_ctrl.osc_en))
      else $error("power-down left the RC oscillator on");
   a_idle_resume: assert property (
      mode_r == 3'h1 && !clk_ctrl.cpu_en && irq_req |-> ##[1:3] clk_ctrl.cpu_en)
      else $error("interrupt did not end idle");
   a_sleep_hold: assert property (
      !clk_ctrl.cpu_en && clk_ctrl.pin_hold |-> per_clk_en == '0 && clk_ctrl.rtc_osc_en)
      else $error("clock running while asleep");
   a_irc_resume: assert property (
      $rose(clk_ctrl.cpu_en) && mode_r == 3'h2 && clk_src_sel == 2'h0 |-> wk_r inside {[3:6]})
      else $error("RC wake count wrong");
   a_main_resume: assert property (
      $rose(clk_ctrl.cpu_en) && mode_r == 3'h2 && clk_src_sel == 2'h1
         |-> wk_r inside {[MAIN_WAKE_CYC - 1:MAIN_WAKE_CYC + 2]})
      else $error("main oscillator wake count wrong");
   a_pdown_resume: assert property (
      $rose(clk_ctrl.cpu_en) && mode_r == 3'h3 |-> wk_r inside {[1203:1208]})
      else $error("power-down wake count wrong");
   a_deep_stays: assert property (
      mode_r == 3'h4 && !clk_ctrl.cpu_en |=> !clk_ctrl.cpu_en)
      else $error("deep power-down left without reset");
   a_gate_off: assert property (
      settle_r == 2'h0 |-> (per_clk_en & ~gate_r) == '0)
      else $error("gated peripheral clock ticked");
endmodule

// ---- bench/pmc_periph_model.sv ----
module pmc_periph_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Core enable, peripheral tick and bench request
   input wire logic cpu_en,
   input wire logic tick,
   input wire logic arm,
   // Interrupt toward the controller
   output logic irq_req
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cnt_r, cnt_nxt;
   logic irq_nxt;

   // Counts its own clock ticks only, so a stopped clock never interrupts
   always_comb begin
      cnt_nxt = (tick && cnt_r != 3'h4) ? cnt_r + 3'h1 : cnt_r;
      if (!arm)
         cnt_nxt = 3'h0;
      irq_nxt = arm && cnt_r == 3'h4 && !cpu_en;
   end

   // Interrupt level drops once the core runs again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 3'h0;
         irq_req <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         irq_req <= irq_nxt;
      end
   end
endmodule

// ---- bench/pmc_top_bench.sv ----
module pmc_top_bench
   import pmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MWC = 8;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic wake_pin = 1'b0;
   logic arm = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq_req, se;
   logic [1:0] clk_src_sel;
   logic [7:0] pll_mul, cpu_div, usb_div;
   logic [15:0] per_clk_en;
   pmc_clk_ctrl_t clk_ctrl, c;
   int errors = 0;
   int n_checks = 0;

   always #25 pclk = ~pclk;

   pmc_top #(.NPER(16), .MAIN_WAKE_CYC(MWC)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_req, .wake_pin, .clk_ctrl,
      .clk_src_sel, .pll_mul, .cpu_div, .usb_div, .per_clk_en);
   pmc_periph_model periph (.pclk, .presetn, .cpu_en(clk_ctrl.cpu_en), .tick(per_clk_en[0]),
      .arm, .irq_req);

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      if (errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_cpu(output int n);
      for (n = 0; n < 3000 && clk_ctrl.cpu_en !== 1'b1; n++)
         @(negedge pclk);
      @(posedge pclk);
   endtask

   function automatic logic pulse_ok(int k, logic en, logic [1:0] code);
      return en ? (k >= (64 >> code) - 1 && k <= (64 >> code) + 1) : (k == 0);
   endfunction

   // Sleep or power-down round trip with fresh clock settings
   task automatic nap(input logic [2:0] m, input logic [1:0] s, input int cyc);
      int n;
      logic [7:0] d;
      d = 8'($urandom_range(255, 1));
      apb(1'b1, 8'h04, {30'h0, s});
      apb(1'b1, 8'h08, 32'h00000303);
      apb(1'b1, 8'h0C, {24'h0, d});
      apb(1'b1, 8'h10, {24'h0, d});
      @(negedge pclk);
      c = clk_ctrl;
      check("cpu_clk", {clk_src_sel, pll_mul, cpu_div, usb_div, c.pll_en, c.pll_con, c.osc_en,
         c.irc_out_en, c.pin_hold}, {s, 8'h03, d, d, 2'b11, s == 2'h1, s == 2'h0, 1'b0});
      apb(1'b1, 8'h00, {29'h0, m});
      repeat (3) @(negedge pclk);
      c = clk_ctrl;
      check("nap_ctrl", c, {3'b000, m == 3'h2, 5'b00111});
      check("nap_div", {cpu_div, usb_div, per_clk_en}, 32'h0);
      @(posedge pclk);
      wake_pin <= 1'b1;
      wait_cpu(n);
      wake_pin <= 1'b0;
      check("wake_time", n > cyc && n <= cyc + 6, 1'b1);
      apb(1'b0, 8'h00, 32'h0);
      check("mode_back", rd, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      check("pll_off", rd, 32'h00000300);
      apb(1'b0, 8'h1C, 32'h0);
      check("wake_flag", rd[8], 1'b1);
      apb(1'b1, 8'h1C, 32'h00000100);
      apb(1'b0, 8'h1C, 32'h0);
      check("wake_clr", rd, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      check("gate_kept", rd, 32'h0000FFFF);
   endtask

   initial begin
      int cnt[16];
      int n;
      logic [15:0] g;
      logic [31:0] p;
      void'($urandom(32'h8e0d));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h14, 32'h0);
      check("gate_rst", rd, 32'h0000FFFF);
      apb(1'b0, 8'h24, 32'h0);
      check("slverr", se, 1'b1);
      // Refused codes leave MODE and CLKSRC as they were
      apb(1'b1, 8'h00, 32'h7);
      apb(1'b1, 8'h04, 32'h2);
      apb(1'b1, 8'h04, 32'h3);
      apb(1'b0, 8'h00, 32'h0);
      check("mode_bad", rd, 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      check("src_bad", rd, 32'h2);
      // Gates and dividers: corner values first, then random
      for (int r = 0; r < 3; r++) begin
         g = (r == 0) ? 16'hFFFF : (r == 1) ? 16'hA5A5 : 16'($urandom);
         p = (r == 0) ? 32'h0 : (r == 1) ? 32'hFFFFFFFF : $urandom;
         apb(1'b1, 8'h14, {16'h0, g});
         apb(1'b1, 8'h18, p);
         repeat (4) @(posedge pclk);
         cnt = '{default: 0};
         repeat (64) begin
            @(negedge pclk);
            foreach (cnt[i])
               cnt[i] += int'(per_clk_en[i]);
         end
         foreach (cnt[i])
            check("per_clk", pulse_ok(cnt[i], g[i], p[2*i+:2]), 1'b1);
      end
      // Idle: a peripheral on a running clock must wake the core
      apb(1'b1, 8'h14, 32'h0000FFFF);
      apb(1'b1, 8'h18, 32'h0);
      apb(1'b1, 8'h00, 32'h1);
      arm <= 1'b1;
      repeat (3) @(negedge pclk);
      check("idle_halt", clk_ctrl.cpu_en, 1'b0);
      wait_cpu(n);
      arm <= 1'b0;
      check("idle_wake", n < 40, 1'b1);
      nap(3'h2, 2'h0, 4);
      nap(3'h2, 2'h1, MWC);
      nap(3'h3, 2'h0, 1204);
      // Deep power-down ignores the wake pin; only reset ends it
      apb(1'b1, 8'h00, 32'h4);
      wake_pin <= 1'b1;
      repeat (60) @(negedge pclk);
      check("deep_hold", clk_ctrl, 9'h005);
      @(posedge pclk);
      presetn <= 1'b0;
      wake_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      check("deep_exit", clk_ctrl, 9'h163);
      apb(1'b0, 8'h00, 32'h0);
      check("mode_rst", rd, 32'h0);
      summarize();
   end

   // Watchdog well beyond the expected run of under two thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      summarize();
   end
endmodule

bind pmc_top pmc_properties #(.NPER(NPER), .MAIN_WAKE_CYC(MAIN_WAKE_CYC)) u_props (.pclk,
   .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_req,
   .wake_pin, .clk_ctrl, .clk_src_sel, .pll_mul, .cpu_div, .usb_div, .per_clk_en);
